//--- src/tls_supervisor.v
// torque limit combiner and stall trip timer with an AXI4-Lite register slave
// How it works
// (R1) stall time is programmable from 0.1 s to 3000.0 s in 0.1 s steps, default 120.0 s.
// (R2) the limit type bit selects torque compare (0, default) or current compare (1).
// (R3) in torque mode the trip rises once load stays above the torque bound beyond the stall time.
// (R4) in torque mode the timer returns to zero whenever load falls below the torque bound.
// (R5) in current mode the trip rises once current stays above its limit beyond the stall time.
// (R6) in current mode the timer returns to zero whenever current falls below its limit.
// (R7) torque above the final positive bound asks the speed loop to hold torque at that bound.
// (R8) torque below the final negative bound asks the speed loop to hold torque at that bound.
// (R9) final bounds are the tightest of the positive/negative settings, the main or halt bound in force and current limit action, readable back.
// (R10) positive and negative settings span -300.00 to 300.00 %, defaults 150.00 and -150.00 %.
// (R11) a symmetric main bound of 0.00 to 300.00 %, default 150.00 %, caps both directions.
// (R12) a quick halt bound of 0.00 to 300.00 %, default 150.00 %, replaces them during fast stop.
// (R13) when the mirror flag is set the negative setting follows the negated positive setting.
// (R14) the trip stays set until trip logic clears it, and the timer holds zero while stopped.
`timescale 1ns/100ps
`include "tls_map.vh"
module tls_supervisor #(
  parameter TICK_CYCLES = `TLS_TICK_NS / `TLS_CLK_NS
) (
  input wire mclk,
  input wire rstn,
  input wire [5:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [5:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire signed [15:0] estTorque,
  input wire signed [15:0] estLoad,
  input wire [15:0] measCurrent,
  input wire [15:0] currentLimit,
  input wire signed [15:0] currentBoundPos,
  input wire signed [15:0] currentBoundNeg,
  input wire quickHalt,
  input wire driveRunning,
  input wire tripClear,
  output reg stallTrip,
  output reg holdPos,
  output reg holdNeg,
  output reg signed [15:0] finalPositiveBound,
  output reg signed [15:0] finalNegativeBound
);
  // settings in 0.01 % of rated torque; stall time in 0.1 s units
  reg signed [15:0] positiveBoundSetting_r;
  reg signed [15:0] negativeBoundSetting_r;
  reg signed [15:0] symmetricMainBound_r;
  reg signed [15:0] quickHaltBound_r;
  reg mirrorBoundsFlag_r;
  reg limType_r;
  reg [15:0] stallTime_r;
  reg [15:0] stallTimer_r;
  reg [26:0] tickCnt_r;
  reg awHeld_r;
  reg wHeld_r;
  reg [5:0] awAddr_r;
  reg [31:0] wData_r;
  reg [3:0] wStrb_r;
  wire doWrite;
  wire signed [15:0] wVal;
  wire signed [15:0] negSetting;
  wire signed [15:0] mainCap;
  wire signed [15:0] posCand;
  wire signed [15:0] negCand;
  wire signed [15:0] posFinal;
  wire signed [15:0] negFinal;
  wire overBound;
  wire tick;

  function signed [15:0] clampS;
    input signed [15:0] v;
    input signed [15:0] lo;
    input signed [15:0] hi;
    begin
      if (v < lo) begin
        clampS = lo;
      end else if (v > hi) begin
        clampS = hi;
      end else begin
        clampS = v;
      end
    end
  endfunction

  function signed [15:0] minS;
    input signed [15:0] a;
    input signed [15:0] b;
    begin
      if (a < b) begin
        minS = a;
      end else begin
        minS = b;
      end
    end
  endfunction

  function signed [15:0] maxS;
    input signed [15:0] a;
    input signed [15:0] b;
    begin
      if (a > b) begin
        maxS = a;
      end else begin
        maxS = b;
      end
    end
  endfunction

  // write path: address and data may arrive in either order, one write in flight
  assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_r && !s_axi_bvalid;
  assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
  assign wVal = wData_r[15:0];
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= 6'h00;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      positiveBoundSetting_r <= `TLS_POS_DEF;
      negativeBoundSetting_r <= `TLS_NEG_DEF;
      symmetricMainBound_r <= `TLS_MAIN_DEF;
      quickHaltBound_r <= `TLS_HALT_DEF;
      mirrorBoundsFlag_r <= 1'b0;
      limType_r <= 1'b0;
      stallTime_r <= `TLS_STALL_DEF;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (doWrite) begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'b00;
        // values are taken only when both low byte lanes are enabled
        if (wStrb_r[1:0] == 2'b11) begin
          case (awAddr_r)
            `TLS_OFF_POS_BOUND: begin
              positiveBoundSetting_r <= clampS(wVal, `TLS_BOUND_MIN, `TLS_BOUND_MAX); // see (R10)
            end
            `TLS_OFF_NEG_BOUND: begin
              negativeBoundSetting_r <= clampS(wVal, `TLS_BOUND_MIN, `TLS_BOUND_MAX); // see (R10)
            end
            `TLS_OFF_MAIN_BOUND: begin
              symmetricMainBound_r <= clampS(wVal, 16'sd0, `TLS_BOUND_MAX); // see (R11)
            end
            `TLS_OFF_HALT_BOUND: begin
              quickHaltBound_r <= clampS(wVal, 16'sd0, `TLS_BOUND_MAX); // see (R12)
            end
            `TLS_OFF_CTRL: begin
              mirrorBoundsFlag_r <= wData_r[`TLS_CTRL_MIRROR];
              limType_r <= wData_r[`TLS_CTRL_LIMTYPE]; // see (R2)
            end
            `TLS_OFF_STALL_TIME: begin
              // see (R1)
              if (wData_r[15:0] < `TLS_STALL_MIN) begin
                stallTime_r <= `TLS_STALL_MIN;
              end else if (wData_r[15:0] > `TLS_STALL_MAX) begin
                stallTime_r <= `TLS_STALL_MAX;
              end else begin
                stallTime_r <= wData_r[15:0];
              end
            end
            default: begin
            end
          endcase
        end
        if (awAddr_r > `TLS_OFF_TIMER) begin
          s_axi_bresp <= 2'b10;
        end
      end
    end
  end

  // read path: one cycle after the address is taken
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else begin
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        // signed settings read back sign-extended so software sees plain 32-bit integers
        case (s_axi_araddr)
          `TLS_OFF_POS_BOUND: begin
            s_axi_rdata <= {{16{positiveBoundSetting_r[15]}}, positiveBoundSetting_r};
          end
          `TLS_OFF_NEG_BOUND: begin
            s_axi_rdata <= {{16{negSetting[15]}}, negSetting};
          end
          `TLS_OFF_MAIN_BOUND: begin
            s_axi_rdata <= {16'h0000, symmetricMainBound_r};
          end
          `TLS_OFF_HALT_BOUND: begin
            s_axi_rdata <= {16'h0000, quickHaltBound_r};
          end
          `TLS_OFF_CTRL: begin
            s_axi_rdata <= {30'h0, limType_r, mirrorBoundsFlag_r};
          end
          `TLS_OFF_STALL_TIME: begin
            s_axi_rdata <= {16'h0000, stallTime_r};
          end
          `TLS_OFF_FINAL_POS: begin
            s_axi_rdata <= {{16{finalPositiveBound[15]}}, finalPositiveBound};
          end
          `TLS_OFF_FINAL_NEG: begin
            s_axi_rdata <= {{16{finalNegativeBound[15]}}, finalNegativeBound};
          end
          `TLS_OFF_STATUS: begin
            s_axi_rdata <= {29'h0, holdNeg, holdPos, stallTrip};
          end
          `TLS_OFF_TIMER: begin
            s_axi_rdata <= {16'h0000, stallTimer_r};
          end
          // unaligned and unmapped offsets answer with a slave error
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end
    end
  end

  // limit combination; main and halt bounds are magnitudes applied in both directions
  assign negSetting = mirrorBoundsFlag_r ? -positiveBoundSetting_r : negativeBoundSetting_r; // see (R13)
  assign mainCap = quickHalt ? quickHaltBound_r : symmetricMainBound_r; // see (R12)
  assign posCand = minS(positiveBoundSetting_r, mainCap); // see (R11)
  assign negCand = maxS(negSetting, -mainCap); // see (R11)
  assign posFinal = minS(posCand, currentBoundPos); // see (R9)
  assign negFinal = maxS(negCand, currentBoundNeg); // see (R9)

  // 0.1 s tick for the stall timer; the tick grid runs free, so a trip may land
  // up to one tick later than the programmed time
  assign tick = (tickCnt_r == TICK_CYCLES - 1);
  // compare against the active bound; exact equality counts as not exceeding
  assign overBound = limType_r ? (measCurrent > currentLimit) : (estLoad > posFinal); // see (R2)

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tickCnt_r <= 27'd0;
      stallTimer_r <= 16'd0;
      stallTrip <= 1'b0;
      holdPos <= 1'b0;
      holdNeg <= 1'b0;
      finalPositiveBound <= `TLS_POS_DEF;
      finalNegativeBound <= `TLS_NEG_DEF;
    end else begin
      finalPositiveBound <= posFinal; // see (R9)
      finalNegativeBound <= negFinal; // see (R9)
      holdPos <= (estTorque > posFinal); // see (R7)
      holdNeg <= (estTorque < negFinal); // see (R8)
      tickCnt_r <= tick ? 27'd0 : tickCnt_r + 27'd1;
      if (!driveRunning || !overBound) begin
        // see (R4) (R6) (R14)
        stallTimer_r <= 16'd0;
      end else if (tick && stallTimer_r != 16'hffff) begin
        stallTimer_r <= stallTimer_r + 16'd1;
      end
      // a new stall in the clearing cycle wins over the clear
      if (driveRunning && overBound && stallTimer_r > stallTime_r) begin
        stallTrip <= 1'b1; // see (R3) (R5)
      end else if (tripClear) begin
        stallTrip <= 1'b0; // see (R14)
      end
    end
  end
endmodule

//--- src/tls_map.vh
// register map, field layout, reset values and timing constants of the torque stall supervisor
`ifndef TLS_MAP_VH
`define TLS_MAP_VH
`define TLS_ADDR_W 6
`define TLS_OFF_POS_BOUND 6'h00
`define TLS_OFF_NEG_BOUND 6'h04
`define TLS_OFF_MAIN_BOUND 6'h08
`define TLS_OFF_HALT_BOUND 6'h0c
`define TLS_OFF_CTRL 6'h10
`define TLS_OFF_STALL_TIME 6'h14
`define TLS_OFF_FINAL_POS 6'h18
`define TLS_OFF_FINAL_NEG 6'h1c
`define TLS_OFF_STATUS 6'h20
`define TLS_OFF_TIMER 6'h24
`define TLS_CTRL_MIRROR 0
`define TLS_CTRL_LIMTYPE 1
`define TLS_CTRL_TRIPCLR 2
`define TLS_POS_DEF 16'sd15000
`define TLS_NEG_DEF -16'sd15000
`define TLS_MAIN_DEF 16'sd15000
`define TLS_HALT_DEF 16'sd15000
`define TLS_BOUND_MAX 16'sd30000
`define TLS_BOUND_MIN -16'sd30000
`define TLS_STALL_DEF 16'd1200
`define TLS_STALL_MIN 16'd1
`define TLS_STALL_MAX 16'd30000
`define TLS_TICK_NS 100000000
`define TLS_CLK_NS 10
`endif

//--- testbench/tls_supervisor_sva.sv
// port assertions for the torque stall supervisor
`timescale 1ns/100ps
module tls_supervisor_sva #(
  parameter TICK_CYCLES = 4
) (
  input wire mclk,
  input wire rstn,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire signed [15:0] estTorque,
  input wire signed [15:0] currentBoundPos,
  input wire signed [15:0] currentBoundNeg,
  input wire driveRunning,
  input wire tripClear,
  input wire stallTrip,
  input wire holdPos,
  input wire holdNeg,
  input wire signed [15:0] finalPositiveBound,
  input wire signed [15:0] finalNegativeBound
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // three stopped cycles let the held-zero timer settle before judging the trip
  sequence stopped;
    !driveRunning [*3];
  endsequence
  // the registered final bound now equals the combined bound that the hold flag was judged on
  hold_pos_a: assert property (holdPos == ($past(estTorque) > finalPositiveBound))
    else $error("holdPos does not follow torque above the positive bound");
  hold_neg_a: assert property (holdNeg == ($past(estTorque) < finalNegativeBound))
    else $error("holdNeg does not follow torque below the negative bound");
  fin_pos_a: assert property (finalPositiveBound <= $past(currentBoundPos))
    else $error("positive bound looser than current limit action");
  fin_neg_a: assert property (finalNegativeBound >= $past(currentBoundNeg))
    else $error("negative bound looser than current limit action");
  trip_hold_a: assert property (stallTrip && !tripClear |=> stallTrip)
    else $error("stall trip dropped without a clear");
  stop_clear_a: assert property (stopped ##0 tripClear |=> !stallTrip)
    else $error("stall trip not cleared while stopped");
  stop_trip_a: assert property (stopped |=> !$rose(stallTrip))
    else $error("stall trip raised while the drive is stopped");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response changed before it was accepted");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before it was accepted");
endmodule
bind tls_supervisor tls_supervisor_sva #(.TICK_CYCLES(TICK_CYCLES)) tls_supervisor_sva_inst (
  .mclk, .rstn, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .estTorque, .currentBoundPos, .currentBoundNeg, .driveRunning, .tripClear,
  .stallTrip, .holdPos, .holdNeg, .finalPositiveBound, .finalNegativeBound);

//--- testbench/tls_drive_model.sv
// behavioural speed loop that pulls torque back onto the final bounds
`timescale 1ns/100ps
module tls_drive_model (
  input wire mclk,
  input wire rstn,
  input wire signed [15:0] demand,
  input wire holdPos,
  input wire holdNeg,
  input wire signed [15:0] finalPositiveBound,
  input wire signed [15:0] finalNegativeBound,
  output logic signed [15:0] estTorque
);
  // speed is trimmed so torque sits on the bound, so hold flags toggle while demand is beyond it
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) estTorque <= 16'sh0;
    else if (holdPos) estTorque <= finalPositiveBound;
    else if (holdNeg) estTorque <= finalNegativeBound;
    else estTorque <= demand;
  end
endmodule

//--- testbench/tb_tls_supervisor.sv
// self-checking bench for the torque stall supervisor
`timescale 1ns/100ps
module tb_tls_supervisor;
  typedef struct {logic [5:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} tls_row_t;
  logic mclk = '0, rstn = '0, quickHalt = '0, driveRunning = '0, tripClear = '0;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0;
  logic s_axi_rready = '0;
  logic [5:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, d;
  logic [15:0] measCurrent = '0, currentLimit = 16'h0200;
  logic signed [15:0] estLoad = '0, demand = '0, currentBoundPos = 16'sh7530;
  logic signed [15:0] currentBoundNeg = 16'sh8ad0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire stallTrip, holdPos, holdNeg;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire signed [15:0] estTorque, finalPositiveBound, finalNegativeBound;
  logic [1:0] r;
  int bad_count = 0, comparisons = 0, i, n;
  logic [31:0] rstVals [10] = '{32'h3a98, 32'hffffc568, 32'h3a98, 32'h3a98, 32'h0, 32'h4b0,
    32'h3a98, 32'hffffc568, 32'h0, 32'h0};
  tls_row_t rows [9] = '{'{6'h00, 32'h7918, 32'h7530, 2'h0}, '{6'h04, 32'hffff8300,
    32'hffff8ad0, 2'h0}, '{6'h08, 32'hfffffffb, 32'h0, 2'h0}, '{6'h08, 32'h2710, 32'h2710,
    2'h0}, '{6'h0c, 32'h1388, 32'h1388, 2'h0}, '{6'h14, 32'h0, 32'h1, 2'h0}, '{6'h14,
    32'h7918, 32'h7530, 2'h0}, '{6'h14, 32'h2, 32'h2, 2'h0}, '{6'h28, 32'h5, 32'h0, 2'h2}};
  tls_supervisor #(.TICK_CYCLES(4)) tls_supervisor_inst (.mclk, .rstn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .estTorque,
    .estLoad, .measCurrent, .currentLimit, .currentBoundPos, .currentBoundNeg, .quickHalt,
    .driveRunning, .tripClear, .stallTrip, .holdPos, .holdNeg, .finalPositiveBound,
    .finalNegativeBound);
  tls_drive_model tls_drive_model_inst (.mclk, .rstn, .demand, .holdPos, .holdNeg,
    .finalPositiveBound, .finalNegativeBound, .estTorque);
  always #5 mclk = ~mclk;
  task summarize;
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // bready and rready go high with the request and stay high, so the answer is taken at once
  task wr(input logic [5:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    if (n == 40) begin bad_count++; summarize(); end
  endtask
  task rd(input logic [5:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    if (n == 40) begin bad_count++; summarize(); end
  endtask
  task level(input logic signed [15:0] ld, input logic [15:0] cur, input int cyc);
    estLoad <= ld;
    measCurrent <= cur;
    repeat (cyc) @(posedge mclk);
  endtask
  task clr;
    tripClear <= 1'b1;
    @(posedge mclk);
    tripClear <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    for (i = 0; i < 10; i++) begin
      rd(6'(i * 4));
      chk(d, rstVals[i]);
    end
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      chk(r, rows[i].r);
      rd(rows[i].a);
      chk(r, rows[i].r);
      if (rows[i].r == 2'h0) chk(d, rows[i].e);
    end
    chk(finalPositiveBound, 32'h2710);
    chk(finalNegativeBound, 32'hffffd8f0);
    currentBoundPos <= 16'sh1f40;
    quickHalt <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(finalPositiveBound, 32'h1388);
    chk(finalNegativeBound, 32'hffffec78);
    quickHalt <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(finalPositiveBound, 32'h1f40);
    currentBoundPos <= 16'sh7530;
    wr(6'h00, 32'h1770);
    wr(6'h10, 32'h1);
    rd(6'h04);
    chk(d, 32'hffffe890);
    chk(finalNegativeBound, 32'hffffe890);
    wr(6'h10, 32'h0);
    demand <= 16'sd9000;
    repeat (3) @(posedge mclk);
    chk(holdPos, 1'b1);
    // the loop model first pulls torque back onto the positive bound before following demand
    demand <= -16'sd12000;
    repeat (4) @(posedge mclk);
    chk(holdNeg, 1'b1);
    demand <= 16'sh0;
    driveRunning <= 1'b1;
    level(16'sd7000, 16'h0, 6);
    chk(stallTrip, 1'b0);
    level(16'sd6000, 16'h0, 1);
    level(16'sd7000, 16'h0, 6);
    chk(stallTrip, 1'b0);
    level(16'sd7000, 16'h0, 30);
    chk(stallTrip, 1'b1);
    level(16'sh0, 16'h0, 5);
    chk(stallTrip, 1'b1);
    rd(6'h20);
    chk(d[0], 1'b1);
    clr();
    chk(stallTrip, 1'b0);
    wr(6'h10, 32'h2);
    level(16'sd7000, 16'h0, 30);
    chk(stallTrip, 1'b0);
    level(16'sh0, 16'h0300, 6);
    level(16'sh0, 16'h0200, 1);
    level(16'sh0, 16'h0300, 6);
    chk(stallTrip, 1'b0);
    level(16'sh0, 16'h0300, 30);
    chk(stallTrip, 1'b1);
    driveRunning <= 1'b0;
    level(16'sh0, 16'h0300, 3);
    clr();
    level(16'sh0, 16'h0300, 40);
    chk(stallTrip, 1'b0);
    rd(6'h24);
    chk(d, 32'h0);
    // reset in mid-run brings the settings back to their defaults
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    rd(6'h14);
    chk(d, 32'h4b0);
    rd(6'h04);
    chk(d, 32'hffffc568);
    rd(6'h10);
    chk(d, 32'h0);
    summarize();
  end
endmodule
